/* File: hw/vpic_ctrl.sv */
// Sixteen-input vectored interrupt controller with CPU I/O registers
`timescale 1ns/1ps
module vpic_ctrl (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic [15:0] request_input_in,
   input wire logic [7:0] io_addr_in,
   input wire logic [7:0] io_wdata_in,
   input wire logic io_wr_in,
   input wire logic io_rd_in,
   output logic [7:0] io_rdata_out,
   input wire logic ack_from_cpu_n_in,
   input wire logic service_done_n_in,
   output logic cpu_irq_n_out,
   output logic [7:0] vector_out,
   output logic vector_valid_out
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [15:0] sync1;
      logic [15:0] sync2;
      logic [15:0] sync3;
      logic [15:0] level;
      logic [15:0] edge_pend;
      logic [15:0] trigger_select;
      logic [15:0] group_select;
      logic [15:0] request_mask;
      logic [15:0] in_service_bits;
      logic [2:0] vector_base;
      logic base_written;
      vpic_pkg::vpic_mode_e mode;
      logic ack_prev_n;
      logic done_prev_n;
      logic irq_n;
      logic [7:0] vector;
      logic vector_valid;
      logic [7:0] rdata;
   } vpic_state_s;

   vpic_state_s r;
   vpic_state_s next_r;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [15:0] vpic_onehot(input logic [3:0] idx);
      vpic_onehot = vpic_pkg::RST_ZERO;
      vpic_onehot[idx] = 1'h1;
   endfunction : vpic_onehot

   function automatic logic vpic_hit(input logic [7:0] addr, input logic [7:0] want);
      vpic_hit = (addr == want);
   endfunction : vpic_hit

   // ----------------------------------------
   // Pending requests
   // ----------------------------------------
   logic [15:0] pending_request_bits;
   logic [15:0] eligible;

   genvar g;
   generate
      for (g = 0; g < vpic_pkg::NUM_IN; g++) begin : g_pend
         // Level input follows the pin, edge input follows its latch
         assign pending_request_bits[g] = (r.trigger_select[g] == vpic_pkg::TRIG_EDGE) ?
                                          r.edge_pend[g] : r.level[g];
         assign eligible[g] = pending_request_bits[g] & ~r.request_mask[g];
      end
   endgenerate

   // ----------------------------------------
   // Request filter
   // ----------------------------------------
   logic [15:0] level_next;

   generate
      for (g = 0; g < vpic_pkg::NUM_IN; g++) begin : g_filt
         // A glitch seen by one stage only never reaches the request logic
         assign level_next[g] = (r.sync2[g] == r.sync3[g]) ? r.sync3[g] : r.level[g];
      end
   endgenerate

   // ----------------------------------------
   // CPU strobe edges
   // ----------------------------------------
   logic ack_fall;
   logic done_fall;

   // Strobes share this clock, so an edge is a change against last cycle
   assign ack_fall = r.ack_prev_n && !ack_from_cpu_n_in;
   assign done_fall = r.done_prev_n && !service_done_n_in;

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   logic wr_low;
   logic wr_high;
   logic wr_mask_low;
   logic wr_mask_high;

   // Write-only halves share an address with reads; the base flag steers them
   assign wr_low = io_wr_in && vpic_hit(io_addr_in, vpic_pkg::ADDR_LOW);
   assign wr_high = io_wr_in && vpic_hit(io_addr_in, vpic_pkg::ADDR_HIGH);
   assign wr_mask_low = io_wr_in && vpic_hit(io_addr_in, vpic_pkg::ADDR_MASK_LOW);
   assign wr_mask_high = io_wr_in && vpic_hit(io_addr_in, vpic_pkg::ADDR_MASK_HIGH);

   // ----------------------------------------
   // Arbitration
   // ----------------------------------------
   logic win_found;
   logic [4:0] win_key;
   logic isr_found;
   logic [4:0] isr_key;
   logic outranks;

   vpic_prio_enc u_win (
      .req_in(eligible),
      .group_in(r.group_select),
      .found_out(win_found),
      .key_out(win_key)
   );

   vpic_prio_enc u_isr (
      .req_in(r.in_service_bits),
      .group_in(r.group_select),
      .found_out(isr_found),
      .key_out(isr_key)
   );

   // Nesting: a request must beat the highest level now in service
   assign outranks = win_found && (!isr_found || win_key > isr_key);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [15:0] rise;
      logic [15:0] edge_clr;
      logic [15:0] isr_set;
      logic [15:0] isr_clr;
      rise = vpic_pkg::RST_ZERO;
      edge_clr = vpic_pkg::RST_ZERO;
      isr_set = vpic_pkg::RST_ZERO;
      isr_clr = vpic_pkg::RST_ZERO;
      next_r = r;

      // Pins are asynchronous; a change counts once stages two and three agree
      next_r.sync1 = request_input_in;
      next_r.sync2 = r.sync1;
      next_r.sync3 = r.sync2;
      next_r.level = level_next;
      rise = next_r.level & ~r.level;

      // Last strobe levels, for the edge detectors
      next_r.ack_prev_n = ack_from_cpu_n_in;
      next_r.done_prev_n = service_done_n_in;

      // Acknowledge
      if (ack_fall) begin
         if (r.mode == vpic_pkg::VPIC_NORMAL && outranks) begin
            isr_set = vpic_onehot(win_key[3:0]);
            if (r.trigger_select[win_key[3:0]] == vpic_pkg::TRIG_EDGE) begin
               edge_clr = vpic_onehot(win_key[3:0]);
            end
            next_r.vector = {r.vector_base, win_key[3:0], 1'h0};
         end else begin
            // Request vanished: level-0 vector, nothing put in service
            next_r.vector = {r.vector_base, vpic_pkg::LEVEL0_IDX, 1'h0};
            next_r.mode = vpic_pkg::VPIC_ILLEGAL;
         end
      end
      next_r.vector_valid = !ack_from_cpu_n_in && (r.vector_valid || ack_fall);

      // End of service
      if (done_fall) begin
         case (r.mode)
            vpic_pkg::VPIC_ILLEGAL: begin
               next_r.mode = vpic_pkg::VPIC_NORMAL;
            end
            vpic_pkg::VPIC_NORMAL: begin
               if (isr_found) begin
                  isr_clr = vpic_onehot(isr_key[3:0]);
               end
            end
            default: begin
               next_r.mode = vpic_pkg::VPIC_NORMAL;
            end
         endcase
      end
      next_r.in_service_bits = (r.in_service_bits & ~isr_clr) | isr_set;

      // A new edge in the clearing cycle is kept: set wins over clear
      next_r.edge_pend = (r.edge_pend & ~edge_clr) | (rise & r.trigger_select);

      // Interrupt line; illegal state holds it off entirely
      next_r.irq_n = !(outranks && r.mode == vpic_pkg::VPIC_NORMAL);

      // Register writes
      // Ordering is software's duty; a late trigger write lands in group select
      if (wr_low) begin
         if (!r.base_written) begin
            next_r.trigger_select[7:0] = io_wdata_in;
         end else begin
            next_r.group_select[7:0] = io_wdata_in;
         end
      end
      if (wr_high) begin
         if (!r.base_written) begin
            next_r.trigger_select[15:8] = io_wdata_in;
         end else begin
            next_r.group_select[15:8] = io_wdata_in;
         end
      end
      if (wr_mask_low) begin
         next_r.request_mask[7:0] = io_wdata_in;
      end
      if (wr_mask_high) begin
         if (!r.base_written) begin
            next_r.vector_base = io_wdata_in[vpic_pkg::VB_MSB:vpic_pkg::VB_LSB];
            next_r.base_written = 1'h1;
         end else begin
            next_r.request_mask[15:8] = io_wdata_in;
         end
      end

      // Register reads: answer lands one cycle after the strobe and holds
      if (io_rd_in) begin
         if (vpic_hit(io_addr_in, vpic_pkg::ADDR_LOW)) begin
            next_r.rdata = r.in_service_bits[7:0];
         end else if (vpic_hit(io_addr_in, vpic_pkg::ADDR_HIGH)) begin
            next_r.rdata = r.in_service_bits[15:8];
         end else if (vpic_hit(io_addr_in, vpic_pkg::ADDR_MASK_LOW)) begin
            next_r.rdata = r.request_mask[7:0];
         end else if (vpic_hit(io_addr_in, vpic_pkg::ADDR_MASK_HIGH)) begin
            next_r.rdata = r.request_mask[15:8];
         end else begin
            next_r.rdata = vpic_pkg::RD_NONE;
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         r.sync1 <= vpic_pkg::RST_ZERO;
         r.sync2 <= vpic_pkg::RST_ZERO;
         r.sync3 <= vpic_pkg::RST_ZERO;
         r.level <= vpic_pkg::RST_ZERO;
         r.edge_pend <= vpic_pkg::RST_ZERO;
         r.trigger_select <= vpic_pkg::RST_ZERO;
         r.group_select <= vpic_pkg::RST_ZERO;
         r.request_mask <= vpic_pkg::RST_MASK;
         r.in_service_bits <= vpic_pkg::RST_ZERO;
         r.vector_base <= vpic_pkg::RST_VB;
         r.base_written <= 1'h0;
         r.mode <= vpic_pkg::VPIC_NORMAL;
         // Idle strobes read high, so no false edge after release
         r.ack_prev_n <= 1'h1;
         r.done_prev_n <= 1'h1;
         r.irq_n <= 1'h1;
         r.vector <= vpic_pkg::RST_VECTOR;
         r.vector_valid <= 1'h0;
         r.rdata <= vpic_pkg::RD_NONE;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign io_rdata_out = r.rdata;
   assign cpu_irq_n_out = r.irq_n;
   assign vector_out = r.vector;
   assign vector_valid_out = r.vector_valid;
endmodule : vpic_ctrl

/* File: hw/vpic_pkg.sv */
// Constants and types shared by the vectored interrupt controller
package vpic_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int NUM_IN = 16;
   localparam int IDX_W = 4;
   localparam int KEY_W = 5;
   localparam int VB_W = 3;
   localparam int VB_LSB = 5;
   localparam int VB_MSB = 7;
   localparam int BYTE_W = 8;
   // ----------------------------------------
   // CPU I/O addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_LOW = 8'h34;
   localparam logic [7:0] ADDR_HIGH = 8'h35;
   localparam logic [7:0] ADDR_MASK_LOW = 8'h36;
   localparam logic [7:0] ADDR_MASK_HIGH = 8'h37;
   // ----------------------------------------
   // Reset values and fixed codes
   // ----------------------------------------
   localparam logic [15:0] RST_MASK = 16'hFFFF;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [2:0] RST_VB = 3'h0;
   localparam logic [7:0] RD_NONE = 8'h00;
   localparam logic [7:0] RST_VECTOR = 8'h00;
   localparam logic [3:0] LEVEL0_IDX = 4'h0;
   localparam logic [4:0] RST_KEY = 5'h00;
   localparam logic TRIG_LEVEL = 1'h0;
   localparam logic TRIG_EDGE = 1'h1;
   localparam logic GROUP_LOW = 1'h0;
   localparam logic GROUP_HIGH = 1'h1;
   // ----------------------------------------
   // Control modes
   // ----------------------------------------
   typedef enum logic {
      VPIC_NORMAL,
      VPIC_ILLEGAL
   } vpic_mode_e;
endpackage : vpic_pkg

/* File: hw/vpic_prio_enc.sv */
// Priority encoder: highest group first, then highest input number
`timescale 1ns/1ps
module vpic_prio_enc (
   input wire logic [15:0] req_in,
   input wire logic [15:0] group_in,
   output logic found_out,
   output logic [4:0] key_out
);
   // ----------------------------------------
   // Search
   // ----------------------------------------
   // Key is {group, index}, so one compare covers both orderings
   always_comb begin
      logic [4:0] k;
      k = vpic_pkg::RST_KEY;
      found_out = 1'h0;
      key_out = vpic_pkg::RST_KEY;
      for (int i = 0; i < vpic_pkg::NUM_IN; i++) begin
         k = {group_in[i], 4'(i)};
         if (req_in[i] && (!found_out || k > key_out)) begin
            found_out = 1'h1;
            key_out = k;
         end
      end
   end
endmodule : vpic_prio_enc

/* File: tb/vpic_ctrl_monitor.sv */
// Port assertions for the vectored interrupt controller
`timescale 1ns/1ps
module vpic_ctrl_monitor (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic [15:0] request_input_in,
   input wire logic [7:0] io_addr_in,
   input wire logic [7:0] io_wdata_in,
   input wire logic io_wr_in,
   input wire logic io_rd_in,
   input wire logic [7:0] io_rdata_out,
   input wire logic ack_from_cpu_n_in,
   input wire logic service_done_n_in,
   input wire logic cpu_irq_n_out,
   input wire logic [7:0] vector_out,
   input wire logic vector_valid_out
);
   logic ack_q;
   logic fall_q;
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rstn_in);
   // ----
   // Registered ack fall, avoids nested past
   // ----
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ack_q <= 1'h1;
         fall_q <= 1'h0;
      end else begin
         ack_q <= ack_from_cpu_n_in;
         fall_q <= ack_q & ~ack_from_cpu_n_in;
      end
   end
   AST_VEC_LSB: assert property (vector_valid_out |-> !vector_out[0])
      else $error("vector bit 0 set");
   AST_VALID_RISE: assert property (fall_q |-> vector_valid_out)
      else $error("no vector after ack");
   AST_VALID_DROP: assert property ($rose(ack_from_cpu_n_in) |=> !vector_valid_out)
      else $error("vector valid outlives ack");
   AST_VALID_CAUSE: assert property (vector_valid_out |-> !$past(ack_from_cpu_n_in))
      else $error("vector valid without ack");
   AST_VEC_HOLD: assert property (!fall_q |-> $stable(vector_out))
      else $error("vector changed without ack");
   AST_RD_UNMAP: assert property (io_rd_in && (io_addr_in < 8'h34 || io_addr_in > 8'h37)
      |=> io_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   AST_RD_HOLD: assert property (!io_rd_in |=> $stable(io_rdata_out))
      else $error("read data moved without read");
   AST_IRQ_RESET: assert property ($rose(rstn_in) |-> cpu_irq_n_out [*4])
      else $error("irq raised while all masked");
   COV_ACK: cover property (fall_q);
   COV_LEVEL0: cover property (vector_valid_out && vector_out[4:1] == 4'h0);
   COV_IRQ: cover property ($fell(cpu_irq_n_out));
endmodule : vpic_ctrl_monitor
bind vpic_ctrl vpic_ctrl_monitor u_mon (
   .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .request_input_in(request_input_in),
   .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in), .io_wr_in(io_wr_in),
   .io_rd_in(io_rd_in), .io_rdata_out(io_rdata_out), .ack_from_cpu_n_in(ack_from_cpu_n_in),
   .service_done_n_in(service_done_n_in), .cpu_irq_n_out(cpu_irq_n_out),
   .vector_out(vector_out), .vector_valid_out(vector_valid_out)
);

/* File: tb/vpic_cpu_model.sv */
// CPU side model: acknowledge and end-of-service strobes
`timescale 1ns/1ps
module vpic_cpu_model (
   input wire logic ref_clk_in,
   input wire logic cpu_irq_n_in,
   input wire logic vector_valid_in,
   input wire logic [7:0] vector_in,
   output logic ack_n_out,
   output logic done_n_out
);
   initial begin
      ack_n_out = 1'h1;
      done_n_out = 1'h1;
   end
   // ----
   // Ack held until vector seen, then hold_cyc more
   // ----
   task automatic acknowledge(input bit need_irq, input int hold_cyc,
      output logic [7:0] vec, output bit ok);
      int n;
      n = 0;
      while (need_irq && cpu_irq_n_in !== 1'h0 && n < 100) begin
         @(negedge ref_clk_in);
         n++;
      end
      ok = (n < 100);
      @(negedge ref_clk_in);
      ack_n_out = 1'h0;
      n = 0;
      do begin
         @(negedge ref_clk_in);
         n++;
      end while (vector_valid_in !== 1'h1 && n < 10);
      ok = ok && (vector_valid_in === 1'h1);
      vec = vector_in;
      repeat (hold_cyc) @(negedge ref_clk_in);
      ack_n_out = 1'h1;
   endtask : acknowledge
   task automatic end_service();
      @(negedge ref_clk_in);
      done_n_out = 1'h0;
      @(negedge ref_clk_in);
      done_n_out = 1'h1;
   endtask : end_service
endmodule : vpic_cpu_model

/* File: tb/test_vpic_ctrl.sv */
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module test_vpic_ctrl;
   logic ref_clk_in;
   logic rstn_in;
   logic [15:0] req;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic ack_n;
   logic done_n;
   logic irq_n;
   logic [7:0] vec;
   logic vval;
   int err_count;
   int n_tests;
   vpic_ctrl u_dut (
      .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .request_input_in(req),
      .io_addr_in(addr), .io_wdata_in(wdata), .io_wr_in(wr), .io_rd_in(rd),
      .io_rdata_out(rdata), .ack_from_cpu_n_in(ack_n), .service_done_n_in(done_n),
      .cpu_irq_n_out(irq_n), .vector_out(vec), .vector_valid_out(vval)
   );
   vpic_cpu_model u_cpu (
      .ref_clk_in(ref_clk_in), .cpu_irq_n_in(irq_n), .vector_valid_in(vval),
      .vector_in(vec), .ack_n_out(ack_n), .done_n_out(done_n)
   );
   initial begin
      ref_clk_in = 1'h0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_in);
      addr = a;
      wdata = d;
      wr = 1'h1;
      @(negedge ref_clk_in);
      wr = 1'h0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
      @(negedge ref_clk_in);
      addr = a;
      rd = 1'h1;
      @(negedge ref_clk_in);
      rd = 1'h0;
      `CHK("rdata", ex, rdata)
   endtask : rd_chk
   // Six cycles covers the input synchroniser
   task automatic set_req(input int i, input logic v);
      @(negedge ref_clk_in);
      req[i] = v;
      repeat (6) @(negedge ref_clk_in);
   endtask : set_req
   task automatic ack_chk(input bit need, input int hold, input logic [7:0] ex);
      logic [7:0] got;
      bit ok;
      u_cpu.acknowledge(need, hold, got, ok);
      `CHK("ack handshake", 1'h1, ok)
      `CHK("vector", ex, got)
   endtask : ack_chk
   task automatic t_reset();
      rd_chk(8'h36, 8'hFF);
      rd_chk(8'h37, 8'hFF);
      rd_chk(8'h35, 8'h00);
      rd_chk(8'h3A, 8'h00);
   endtask : t_reset
   task automatic t_config();
      wr_reg(8'h34, 8'h08);
      wr_reg(8'h35, 8'h00);
      wr_reg(8'h37, 8'hA0);
      wr_reg(8'h35, 8'h80);
      set_req(14, 1'h1);
      `CHK("irq_n", 1'h1, irq_n)
      wr_reg(8'h36, 8'h00);
      wr_reg(8'h37, 8'h00);
      rd_chk(8'h37, 8'h00);
      `CHK("irq_n", 1'h0, irq_n)
   endtask : t_config
   task automatic t_prio();
      set_req(15, 1'h1);
      set_req(3, 1'h1);
      set_req(3, 1'h0);
      ack_chk(1'h1, 0, 8'hBE);
      rd_chk(8'h35, 8'h80);
      `CHK("irq_n", 1'h1, irq_n)
      set_req(15, 1'h0);
      u_cpu.end_service();
      rd_chk(8'h35, 8'h00);
      ack_chk(1'h1, 5, 8'hBC);
      set_req(15, 1'h1);
      ack_chk(1'h1, 0, 8'hBE);
      rd_chk(8'h35, 8'hC0);
      set_req(15, 1'h0);
      u_cpu.end_service();
      rd_chk(8'h35, 8'h40);
      set_req(14, 1'h0);
      u_cpu.end_service();
      ack_chk(1'h1, 0, 8'hA6);
      rd_chk(8'h34, 8'h08);
      set_req(3, 1'h1);
      set_req(3, 1'h0);
      u_cpu.end_service();
      ack_chk(1'h1, 0, 8'hA6);
      u_cpu.end_service();
      repeat (8) @(negedge ref_clk_in);
      `CHK("irq_n", 1'h1, irq_n)
   endtask : t_prio
   task automatic t_illegal();
      set_req(14, 1'h1);
      set_req(14, 1'h0);
      ack_chk(1'h0, 0, 8'hA0);
      rd_chk(8'h35, 8'h00);
      set_req(14, 1'h1);
      `CHK("irq_n", 1'h1, irq_n)
      u_cpu.end_service();
      rd_chk(8'h34, 8'h00);
      ack_chk(1'h1, 0, 8'hBC);
      u_cpu.end_service();
   endtask : t_illegal
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report
   initial begin
      err_count = 0;
      n_tests = 0;
      rstn_in = 1'h0;
      req = 16'h0000;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'h0;
      rd = 1'h0;
      repeat (20) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      rstn_in = 1'h1;
      t_reset();
      t_config();
      t_prio();
      t_illegal();
      final_report();
   end
   // Run takes a few hundred cycles; 4000 is ample
   initial begin
      #200000;
      err_count++;
      final_report();
   end
endmodule : test_vpic_ctrl
